// ===== hw/sbrx_core.sv
// Two-wire bus interface: configuration, bit timing, data register, slave rx
`default_nettype none
module sbrx_core (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Configuration levels
  input wire logic bus_enable_bit_in,
  input wire logic slave_inhibit_in,
  input wire logic clock_source_sel_hi_in,
  input wire logic clock_source_sel_lo_in,
  input wire logic hw_ack_enable_in,
  input wire logic ack_bit_in,
  input wire logic [6:0] slave_addr_in,
  input wire logic [6:0] slave_addr_mask_in,
  // Software strobes
  input wire logic si_clear_in,
  input wire logic master_start_in,
  input wire logic master_stop_in,
  // Timer overflow pulses
  input wire logic [3:0] timer_ovf_in,
  // Special function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // Bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Status
  output logic si_flag_out,
  output logic ack_request_flag_out,
  output logic ack_rcvd_out,
  output logic arb_lost_out,
  output logic master_out,
  output logic slave_rx_out,
  output logic slave_tx_out
);
  sbrx_pkg::sbrx_state_e state_ff;
  logic scl_q_ff, sda_q_ff, inh_ff, tx_ff, addr_phase_ff, ack_val_ff;
  logic start_req_ff, stop_req_ff, stop_phase_ff, si_pulse_ff;
  logic ack_request_flag_pulse_ff, start_fall_ff;
  logic [3:0] bit_cnt_ff;
  logic [1:0] tick_cnt_ff;
  logic tick_w, timer_en_w, scl_rise, scl_fall, start_det, stop_det;
  logic shift_en, cpu_write, arb_event, hw_ack_val, sw_ack_pending;
  logic [7:0] data_w;

  // Address match under mask, write direction only
  function automatic logic addr_ok(input logic [7:0] rx,
                                   input logic [6:0] own,
                                   input logic [6:0] mask);
    addr_ok = (((rx[sbrx_pkg::ADDR_MSB:sbrx_pkg::ADDR_LSB] ^ own) & mask)
               == 7'h00) && !rx[sbrx_pkg::RW_BIT];
  endfunction : addr_ok

  // Pins are only ever pulled low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  // Bus event detection on the previous pin levels
  assign scl_rise = scl_in & ~scl_q_ff;
  assign scl_fall = ~scl_in & scl_q_ff;
  assign start_det = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
  assign stop_det = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
    end
  end

  // Timer only runs for master work, never for slave reception
  assign timer_en_w = master_ff_w(state_ff) | master_out;
  function automatic logic master_ff_w(input sbrx_pkg::sbrx_state_e s);
    master_ff_w = (s == sbrx_pkg::ST_M_START) || (s == sbrx_pkg::ST_M_STOP);
  endfunction : master_ff_w

  sbrx_bit_timer u_timer (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .timer_ovf_in(timer_ovf_in),
    .source_sel_in({clock_source_sel_hi_in, clock_source_sel_lo_in}),
    .enable_in(timer_en_w),
    .tick_out(tick_w)
  );

  // Software may write the data only while the flag freezes the bus or the bus is disabled
  assign cpu_write = sfr_wr_in && (sfr_addr_in == sbrx_pkg::SHIFT_DATA_ADDR)
                     && (si_flag_out || !bus_enable_bit_in);
  assign shift_en = (state_ff == sbrx_pkg::ST_BIT) && scl_rise
                    && (bit_cnt_ff < sbrx_pkg::ACK_SLOT);
  assign arb_event = shift_en && master_out && tx_ff && !sda_oe_out
                     && !sda_in;
  assign hw_ack_val = addr_phase_ff
                      ? (addr_ok(data_w, slave_addr_in, slave_addr_mask_in)
                         && !inh_ff)
                      : ack_bit_in;
  assign sw_ack_pending = !hw_ack_enable_in && !inh_ff
                          && !(addr_phase_ff && data_w[sbrx_pkg::RW_BIT]);

  sbrx_shift_data u_data (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .load_in(cpu_write),
    .load_data_in(sfr_wdata_in),
    .shift_in(shift_en),
    .bit_in(sda_in),
    .data_out(data_w)
  );

  // Register read port, holds last value between reads
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sfr_rdata_out <= sbrx_pkg::SHIFT_DATA_RESET;
    end else if (sfr_rd_in && sfr_addr_in == sbrx_pkg::SHIFT_DATA_ADDR) begin
      sfr_rdata_out <= data_w;
    end
  end

  // Inhibit sampled at START so a running transfer is not cut short
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      inh_ff <= 1'b0;
    end else if (start_det) begin
      inh_ff <= slave_inhibit_in;
    end
  end

  // Software requests are latched until the sequencer consumes them
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_req_ff <= 1'b0;
      stop_req_ff <= 1'b0;
    end else begin
      if (master_start_in) begin
        start_req_ff <= 1'b1;
      end else if (state_ff == sbrx_pkg::ST_M_START) begin
        start_req_ff <= 1'b0;
      end
      if (master_stop_in) begin
        stop_req_ff <= 1'b1;
      end else if (state_ff == sbrx_pkg::ST_M_STOP) begin
        stop_req_ff <= 1'b0;
      end
    end
  end

  // Interrupt and ack request flags; a set beats a same-cycle clear
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      si_flag_out <= 1'b0;
      ack_request_flag_out <= 1'b0;
    end else begin
      if (si_pulse_ff) begin
        si_flag_out <= 1'b1;
      end else if (si_clear_in) begin
        si_flag_out <= 1'b0;
      end
      if (ack_request_flag_pulse_ff) begin
        ack_request_flag_out <= 1'b1;
      end else if (si_clear_in) begin
        ack_request_flag_out <= 1'b0;
      end
    end
  end

  // Acknowledge seen by our transmitter, arbitration loss record
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_rcvd_out <= 1'b0;
      arb_lost_out <= 1'b0;
    end else begin
      if (state_ff == sbrx_pkg::ST_BIT && scl_rise && tx_ff
          && bit_cnt_ff == sbrx_pkg::ACK_SLOT) begin
        ack_rcvd_out <= !sda_in;
      end
      if (arb_event) begin
        arb_lost_out <= 1'b1;
      end else if (master_start_in) begin
        arb_lost_out <= 1'b0;
      end
    end
  end

  // Mode indications, one cycle behind the sequencer
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      slave_rx_out <= 1'b0;
      slave_tx_out <= 1'b0;
    end else begin
      slave_rx_out <= !master_out && !tx_ff
                      && (state_ff == sbrx_pkg::ST_BIT
                          || state_ff == sbrx_pkg::ST_HOLD);
      slave_tx_out <= !master_out && tx_ff
                      && (state_ff == sbrx_pkg::ST_BIT
                          || state_ff == sbrx_pkg::ST_HOLD);
    end
  end

  // Protocol sequencer with SCL and SDA drivers
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= sbrx_pkg::ST_IDLE;
      master_out <= 1'b0;
      tx_ff <= 1'b0;
      addr_phase_ff <= 1'b0;
      ack_val_ff <= 1'b0;
      stop_phase_ff <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      bit_cnt_ff <= sbrx_pkg::BIT_FIRST;
      tick_cnt_ff <= 2'h0;
      si_pulse_ff <= 1'b0;
      ack_request_flag_pulse_ff <= 1'b0;
      start_fall_ff <= 1'b0;
    end else if (!bus_enable_bit_in) begin
      state_ff <= sbrx_pkg::ST_IDLE;
      master_out <= 1'b0;
      tx_ff <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      bit_cnt_ff <= sbrx_pkg::BIT_FIRST;
      si_pulse_ff <= 1'b0;
      ack_request_flag_pulse_ff <= 1'b0;
      start_fall_ff <= 1'b0;
    end else if (stop_det && !master_out
                 && state_ff != sbrx_pkg::ST_IDLE) begin
      state_ff <= sbrx_pkg::ST_IDLE;
      tx_ff <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      si_pulse_ff <= 1'b0;
      ack_request_flag_pulse_ff <= 1'b0;
      start_fall_ff <= 1'b0; // Stale mark would cost a master its first bit
    end else if (start_det && !master_out
                 && state_ff != sbrx_pkg::ST_M_START) begin
      state_ff <= sbrx_pkg::ST_BIT;
      addr_phase_ff <= 1'b1;
      tx_ff <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      bit_cnt_ff <= sbrx_pkg::BIT_FIRST;
      si_pulse_ff <= 1'b0;
      ack_request_flag_pulse_ff <= 1'b0;
      start_fall_ff <= 1'b1;
    end else begin
      si_pulse_ff <= 1'b0;
      ack_request_flag_pulse_ff <= 1'b0;
      case (state_ff)
        sbrx_pkg::ST_IDLE: begin
          if (start_req_ff && scl_in && sda_in) begin
            state_ff <= sbrx_pkg::ST_M_START;
            sda_oe_out <= 1'b1;
            tick_cnt_ff <= 2'h0;
          end
        end
        sbrx_pkg::ST_M_START: begin
          // START hold lasts a full high phase before SCL goes low
          if (tick_w) begin
            if (tick_cnt_ff + 2'h1 >= sbrx_pkg::HIGH_TICKS) begin
              state_ff <= sbrx_pkg::ST_HOLD;
              scl_oe_out <= 1'b1;
              master_out <= 1'b1;
              tx_ff <= 1'b1;
              bit_cnt_ff <= sbrx_pkg::BIT_FIRST;
              si_pulse_ff <= 1'b1;
            end else begin
              tick_cnt_ff <= tick_cnt_ff + 2'h1;
            end
          end
        end
        sbrx_pkg::ST_HOLD: begin
          // Pulse register covers the cycle before the flag rises
          if (cpu_write && !master_out && !tx_ff) begin
            tx_ff <= 1'b1;
          end
          if (!si_flag_out && !si_pulse_ff) begin
            if (master_out && stop_req_ff) begin
              state_ff <= sbrx_pkg::ST_M_STOP;
              sda_oe_out <= 1'b1;
              stop_phase_ff <= 1'b0;
            end else begin
              state_ff <= sbrx_pkg::ST_BIT;
              if (!master_out) begin
                scl_oe_out <= 1'b0;
              end
              if (!master_out && bit_cnt_ff == sbrx_pkg::ACK_SLOT) begin
                ack_val_ff <= ack_bit_in;
                sda_oe_out <= ack_bit_in;
              end
            end
            tick_cnt_ff <= 2'h0;
          end
        end
        sbrx_pkg::ST_BIT: begin
          // Master clock: low phase from drive, high phase from seen high
          if (master_out) begin
            if (scl_oe_out) begin
              if (tick_w) begin
                if (tick_cnt_ff + 2'h1 >= sbrx_pkg::LOW_TICKS) begin
                  scl_oe_out <= 1'b0;
                  tick_cnt_ff <= 2'h0;
                end else begin
                  tick_cnt_ff <= tick_cnt_ff + 2'h1;
                end
              end
            end else if (scl_in && tick_w) begin
              // Stretched low time does not count toward the high phase
              if (tick_cnt_ff + 2'h1 >= sbrx_pkg::HIGH_TICKS) begin
                scl_oe_out <= 1'b1;
                tick_cnt_ff <= 2'h0;
              end else begin
                tick_cnt_ff <= tick_cnt_ff + 2'h1;
              end
            end
          end
          // Transmit bit follows the MSB only while SCL is low
          if (tx_ff && !scl_in && bit_cnt_ff < sbrx_pkg::ACK_SLOT) begin
            sda_oe_out <= !data_w[7];
          end
          if (arb_event) begin
            master_out <= 1'b0;
            tx_ff <= 1'b0;
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
            addr_phase_ff <= 1'b1;
          end else if (scl_fall && start_fall_ff) begin
            // The fall that closes START opens bit one, it ends no bit
            start_fall_ff <= 1'b0;
          end else if (scl_fall) begin
            if (bit_cnt_ff == sbrx_pkg::BIT_LAST) begin
              bit_cnt_ff <= sbrx_pkg::ACK_SLOT;
              if (tx_ff) begin
                sda_oe_out <= 1'b0;
              end else if (sw_ack_pending) begin
                state_ff <= sbrx_pkg::ST_HOLD;
                scl_oe_out <= 1'b1;
                sda_oe_out <= 1'b0;
                si_pulse_ff <= 1'b1;
                ack_request_flag_pulse_ff <= 1'b1;
              end else begin
                ack_val_ff <= hw_ack_val;
                sda_oe_out <= hw_ack_val;
              end
            end else if (bit_cnt_ff == sbrx_pkg::ACK_SLOT) begin
              bit_cnt_ff <= sbrx_pkg::BIT_FIRST;
              addr_phase_ff <= 1'b0;
              sda_oe_out <= 1'b0;
              if (master_out || tx_ff) begin
                state_ff <= sbrx_pkg::ST_HOLD;
                scl_oe_out <= 1'b1;
                si_pulse_ff <= 1'b1;
              end else if (!ack_val_ff && addr_phase_ff) begin
                state_ff <= sbrx_pkg::ST_IGNORE;
              end else if (hw_ack_enable_in) begin
                state_ff <= sbrx_pkg::ST_HOLD;
                scl_oe_out <= 1'b1;
                si_pulse_ff <= 1'b1;
              end
            end else begin
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
          end
        end
        sbrx_pkg::ST_M_STOP: begin
          // SDA low first, then release SCL, then release SDA
          if (!stop_phase_ff) begin
            if (tick_w) begin
              scl_oe_out <= 1'b0;
              stop_phase_ff <= 1'b1;
            end
          end else if (scl_in && tick_w) begin
            sda_oe_out <= 1'b0;
            master_out <= 1'b0;
            tx_ff <= 1'b0;
            state_ff <= sbrx_pkg::ST_IDLE;
          end
        end
        default: begin
          // Ignored address: wait silently for the next START
          scl_oe_out <= 1'b0;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // Checks on the sequencer
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  a_disable_quiet: assert property (
    !bus_enable_bit_in |=> !scl_oe_out && !sda_oe_out && !master_out)
    else $error("bus driven while disabled");
  a_inhibit_nack: assert property (
    (state_ff == sbrx_pkg::ST_BIT && !master_out && addr_phase_ff && inh_ff
     && bit_cnt_ff == sbrx_pkg::ACK_SLOT && !tx_ff) |-> !sda_oe_out)
    else $error("inhibited slave acknowledged an address");
  a_inhibit_latch: assert property (
    start_det |=> inh_ff == $past(slave_inhibit_in))
    else $error("inhibit not taken at START");
  a_source_sel: assert property (
    timer_en_w |=> tick_w == $past(timer_ovf_in[{clock_source_sel_hi_in,
                                               clock_source_sel_lo_in}]))
    else $error("wrong overflow source");
  a_scl_timing: assert property (
    (master_out && state_ff == sbrx_pkg::ST_BIT && !arb_event
     && ($fell(scl_oe_out) || $rose(scl_oe_out))) |-> $past(tick_w))
    else $error("master SCL edge without overflow");
  a_data_frozen: assert property (
    (si_flag_out && !cpu_write) |=> $stable(data_w))
    else $error("data changed while flag set");
  a_msb_first: assert property (
    shift_en |=> data_w == {$past(data_w[6:0]), $past(sda_in)})
    else $error("bad shift order");
  a_arb_to_slave: assert property (
    arb_event |=> !master_out && state_ff == sbrx_pkg::ST_BIT
                  && arb_lost_out)
    else $error("arbitration loss not handled");
  a_ack_request_flag_slot: assert property (
    $rose(ack_request_flag_out) |-> si_flag_out
                                    && bit_cnt_ff == sbrx_pkg::ACK_SLOT)
    else $error("ack request outside ack slot");
  a_hwack_after: assert property (
    ($rose(si_flag_out) && hw_ack_enable_in && !master_out && !tx_ff)
    |-> bit_cnt_ff == sbrx_pkg::BIT_FIRST)
    else $error("hardware ack interrupt before ack slot");
  a_ignore_quiet: assert property (
    state_ff == sbrx_pkg::ST_IGNORE |=> !si_pulse_ff)
    else $error("interrupt while address ignored");
  a_stop_ends: assert property (
    (stop_det && !master_out && bus_enable_bit_in
     && state_ff == sbrx_pkg::ST_BIT) |=> state_ff == sbrx_pkg::ST_IDLE)
    else $error("STOP did not end slave mode");
  a_stretch_hold: assert property (
    (si_flag_out && state_ff == sbrx_pkg::ST_HOLD) |-> scl_oe_out)
    else $error("SCL released with flag set");

  c_sw_ack_addr: cover property (
    $rose(ack_request_flag_out) && addr_phase_ff);
  c_hw_ack_data: cover property (
    $rose(si_flag_out) && hw_ack_enable_in && slave_rx_out);
  c_arb_lost: cover property (arb_event);
  c_master_byte: cover property (
    $rose(si_flag_out) && master_out && !addr_phase_ff);
endmodule : sbrx_core
`default_nettype wire

// ===== hw/sbrx_pkg.sv
// Shared constants and types for the two-wire serial bus block
`default_nettype none
package sbrx_pkg;
  // Register placement and reset value
  localparam logic [7:0] SHIFT_DATA_ADDR = 8'hc2;
  localparam logic [7:0] SHIFT_DATA_RESET = 8'h00;
  // Clock source select codes
  localparam logic [1:0] CS_TIMER0 = 2'h0;
  localparam logic [1:0] CS_TIMER1 = 2'h1;
  localparam logic [1:0] CS_TIMER2_HI = 2'h2;
  localparam logic [1:0] CS_TIMER2_LO = 2'h3;
  // Bit counter positions within one byte plus acknowledge slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // Master clock phases in overflow periods: high twice the low
  localparam logic [1:0] LOW_TICKS = 2'h1;
  localparam logic [1:0] HIGH_TICKS = 2'h2;
  // Address byte layout
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int RW_BIT = 0;
  // Protocol sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_M_START,
    ST_HOLD,
    ST_BIT,
    ST_M_STOP,
    ST_IGNORE
  } sbrx_state_e;
endpackage : sbrx_pkg
`default_nettype wire

// ===== hw/sbrx_bit_timer.sv
// Overflow source selector producing the master bit-time tick
`default_nettype none
module sbrx_bit_timer (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Overflow sources and selection
  input wire logic [3:0] timer_ovf_in,
  input wire logic [1:0] source_sel_in,
  input wire logic enable_in,
  // Selected overflow pulse
  output logic tick_out
);
  // Registered so the tick is glitch free whatever the source
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= enable_in & timer_ovf_in[source_sel_in];
    end
  end
endmodule : sbrx_bit_timer
`default_nettype wire

// ===== hw/sbrx_shift_data.sv
// Byte-wide shift data register, loaded by software or shifted from SDA
`default_nettype none
module sbrx_shift_data (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Software load
  input wire logic load_in,
  input wire logic [7:0] load_data_in,
  // Serial side
  input wire logic shift_in,
  input wire logic bit_in,
  // Current contents
  output logic [7:0] data_out
);
  // Load wins; shifting only happens while software is locked out
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_out <= sbrx_pkg::SHIFT_DATA_RESET;
    end else if (load_in) begin
      data_out <= load_data_in;
    end else if (shift_in) begin
      data_out <= {data_out[6:0], bit_in};
    end
  end
endmodule : sbrx_shift_data
`default_nettype wire

// ===== dv/sbrx_master_model.sv
// Bus master model driving SCL and SDA through pull-low enables
`default_nettype none
module sbrx_master_model (
  // Clock
  input wire logic clock_in,
  // Bus levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Pull-low enables
  output logic scl_oe_out,
  output logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic hung = 1'b0;
  // Released lines float up to the pull-up level
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tk
  // Release SCL; a slave may stretch it, so wait, but not for ever
  task automatic rise();
    int i;
    scl_oe_out <= 1'b0;
    for (i = 0; i < 3000 && !scl_in; i++) tk(1);
    if (i == 3000) hung = 1'b1;
    tk(6);
  endtask : rise
  task automatic put_bit(input logic b, output logic smp);
    sda_oe_out <= !b;
    tk(4);
    rise();
    smp = sda_in;
    scl_oe_out <= 1'b1;
    tk(4);
  endtask : put_bit
  task automatic start();
    tk(8);
    sda_oe_out <= 1'b1;
    tk(8);
    scl_oe_out <= 1'b1;
    tk(4);
  endtask : start
  // Byte MSB first, then a released acknowledge slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask : send_byte
  task automatic stop();
    sda_oe_out <= 1'b1;
    tk(4);
    rise();
    sda_oe_out <= 1'b0;
    tk(8);
  endtask : stop
endmodule : sbrx_master_model
`default_nettype wire

// ===== dv/sbrx_core_test.sv
// Self-checking bench for the data register, slave receive side and master byte of the bus block
`default_nettype none
module sbrx_core_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in, reset_n_in, en, slave_inhibit, hwack, ackb, clr, rd, wr, ack;
  logic [6:0] own, mask;
  logic [7:0] addr, wd, rdata;
  logic scl_oe, sda_oe, m_scl, m_sda, si, ack_request_flag, srx;
  logic [1:0] sel;
  logic [3:0] ovf;
  logic mstart, mstop, mst;
  int ovf_cnt = 0;
  localparam int OVF_DIV = 5;
  int fail_count = 0;
  int compares = 0;
  // Open-drain wires with pull-ups
  wire scl = !(scl_oe | m_scl);
  wire sda = !(sda_oe | m_sda);
  sbrx_core i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .bus_enable_bit_in(en), .slave_inhibit_in(slave_inhibit),
    .clock_source_sel_hi_in(sel[1]), .clock_source_sel_lo_in(sel[0]),
    .hw_ack_enable_in(hwack), .ack_bit_in(ackb), .slave_addr_in(own),
    .slave_addr_mask_in(mask), .si_clear_in(clr), .master_start_in(mstart),
    .master_stop_in(mstop), .timer_ovf_in(ovf), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wd),
    .sfr_rdata_out(rdata), .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe), .si_flag_out(si),
    .ack_request_flag_out(ack_request_flag), .ack_rcvd_out(), .arb_lost_out(),
    .master_out(mst), .slave_rx_out(srx), .slave_tx_out());
  sbrx_master_model m (.clock_in(clock_in), .scl_in(scl), .sda_in(sda),
    .scl_oe_out(m_scl), .sda_oe_out(m_sda));
  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = !clock_in;
  end
  // Timer 1 overflows every OVF_DIV cycles; timer 0 never does
  always @(negedge clock_in) begin
    ovf_cnt = (ovf_cnt + 1) % OVF_DIV;
    ovf = {2'h0, ovf_cnt == 0, 1'b0};
  end
  task automatic report_and_stop();
    // A stretch that never ended in the model counts as a mismatch
    if (m.hung) fail_count++;
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd_reg(input logic [7:0] exp);
    @(negedge clock_in);
    rd = 1'b1;
    @(negedge clock_in);
    rd = 1'b0;
    chk(rdata, exp);
  endtask : rd_reg
  task automatic wr_reg(input logic [7:0] d);
    @(negedge clock_in);
    wr = 1'b1;
    wd = d;
    @(negedge clock_in);
    wr = 1'b0;
  endtask : wr_reg
  // Bounded wait for the interrupt flag
  task automatic wait_si();
    int i;
    for (i = 0; i < 4000 && si !== 1'b1; i++) @(negedge clock_in);
    if (i == 4000) begin
      fail_count++;
      $display("CHECK FAILED %0t interrupt never came", $time);
      report_and_stop();
    end
  endtask : wait_si
  task automatic clear();
    @(negedge clock_in);
    clr = 1'b1;
    @(negedge clock_in);
    clr = 1'b0;
  endtask : clear
  // Bounded wait for a bus clock level, counting falling clock edges
  task automatic scl_wait(input logic lvl, output int n);
    for (n = 0; n < 200 && scl !== lvl; n++) @(negedge clock_in);
    if (n == 200) begin
      fail_count++;
      $display("CHECK FAILED %0t bus clock stuck", $time);
      report_and_stop();
    end
  endtask : scl_wait
  task automatic t_regs();
    rd_reg(8'h00);
    wr_reg(8'h5a);
    rd_reg(8'h5a);
    en = 1'b1;
    wr_reg(8'hff);
    rd_reg(8'h5a);
  endtask : t_regs
  // Software acknowledge: stretch, flag, NACK of the data byte
  task automatic t_sw();
    fork
      begin m.start(); m.send_byte(8'h58, ack); end
      begin
        wait_si();
        chk(ack_request_flag, 1'b1);
        chk(scl_oe, 1'b1);
        rd_reg(8'h58);
        clear();
      end
    join
    chk(ack, 1'b1);
    chk(srx, 1'b1);
    fork
      m.send_byte(8'ha5, ack);
      begin
        wait_si();
        chk(ack_request_flag, 1'b1);
        rd_reg(8'ha5);
        ackb = 1'b0;
        clear();
      end
    join
    chk(ack, 1'b0);
    m.stop();
    chk(srx, 1'b0);
  endtask : t_sw
  // Hardware acknowledge with masked match and preset NACK
  task automatic t_hw();
    @(negedge clock_in);
    hwack = 1'b1;
    ackb = 1'b1;
    mask = 7'h7c;
    m.start();
    m.send_byte(8'h5e, ack);
    chk(ack, 1'b1);
    wait_si();
    clear();
    ackb = 1'b0;
    m.send_byte(8'h3c, ack);
    chk(ack, 1'b0);
    wait_si();
    rd_reg(8'h3c);
    clear();
    m.stop();
  endtask : t_hw
  // Ignored address, then inhibited slave
  task automatic t_ign();
    @(negedge clock_in);
    mask = 7'h7f;
    m.start();
    m.send_byte(8'h5e, ack);
    chk(ack, 1'b0);
    m.send_byte(8'h11, ack);
    chk(si, 1'b0);
    m.stop();
    @(negedge clock_in);
    hwack = 1'b0;
    slave_inhibit = 1'b1;
    m.start();
    m.send_byte(8'h58, ack);
    chk(ack, 1'b0);
    chk(si, 1'b0);
    chk(m.hung, 1'b0);
    m.stop();
  endtask : t_ign
  // Master byte: START waits for the selected overflow, bit takes three
  task automatic t_mst();
    int hi, lo;
    @(negedge clock_in);
    mstart = 1'b1;
    @(negedge clock_in);
    mstart = 1'b0;
    repeat (40) @(negedge clock_in);
    chk(si, 1'b0);
    sel = 2'h1;
    wait_si();
    chk(mst, 1'b1);
    wr_reg(8'h58);
    clear();
    scl_wait(1'b1, lo);
    scl_wait(1'b0, hi);
    scl_wait(1'b1, lo);
    chk(8'(hi), 8'(2 * OVF_DIV));
    chk(8'(lo), 8'(OVF_DIV));
    wait_si();
    rd_reg(8'h58);
    @(negedge clock_in);
    mstop = 1'b1;
    @(negedge clock_in);
    mstop = 1'b0;
    clear();
  endtask : t_mst
  initial begin
    {reset_n_in, en, slave_inhibit, hwack, clr, rd, wr} = 7'h00;
    {sel, mstart, mstop} = 4'h0;
    ackb = 1'b1;
    own = 7'h2c;
    mask = 7'h7f;
    addr = 8'hc2;
    wd = 8'h00;
    repeat (12) @(negedge clock_in);
    reset_n_in = 1'b1;
    t_regs();
    t_sw();
    t_hw();
    t_ign();
    t_mst();
    report_and_stop();
  end
endmodule : sbrx_core_test
`default_nettype wire
